//--- rtl/rofd_pkg.sv
// Package for the relay output force and disarm block
package rofd_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned NUM_GROUPS    = 2;
    localparam int unsigned OUTS_PER_GRP  = 8;
    localparam int unsigned NUM_OUTS      = NUM_GROUPS * OUTS_PER_GRP;
    localparam int unsigned TMR_W         = 32;
    localparam int unsigned ADDR_W        = 8;

    // Register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] REG_FORCE_EN     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_FORCE_VAL    = 8'h04;
    localparam logic [ADDR_W-1:0] REG_GRP_FORCE    = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FORCE_MODE   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_FORCE_TIME   = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DISARM_CTRL  = 8'h14;
    localparam logic [ADDR_W-1:0] REG_DISARM_MODE  = 8'h18;
    localparam logic [ADDR_W-1:0] REG_DISARM_TIME  = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_COMMAND      = 8'h20;
    localparam logic [ADDR_W-1:0] REG_EXEMPT       = 8'h24;
    localparam logic [ADDR_W-1:0] REG_STATUS       = 8'h28;
    localparam logic [ADDR_W-1:0] REG_OUT_STATE    = 8'h2C;

    // Command register bit positions (write-one pulses)
    localparam int unsigned CMD_FORCE_APPLY  = 0;
    localparam int unsigned CMD_FORCE_REMOVE = 1;
    localparam int unsigned CMD_DISARM_APPLY = 2;
    localparam int unsigned CMD_DISARM_WDRAW = 3;
    localparam int unsigned CMD_REBOOT       = 4;

    // Status register bit positions
    localparam int unsigned ST_SYSTEM_OK     = 0;
    localparam int unsigned ST_FORCE_LO      = 8;
    localparam int unsigned ST_DISARM_LO     = 24;

    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [31:0] RD_UNMAP  = 32'h0000_0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } rofd_bus_req_t;

    typedef struct packed {
        logic [NUM_OUTS-1:0] normal_cmd;
        logic [NUM_OUTS-1:0] latched;
        logic [NUM_OUTS-1:0] hold_run;
    } rofd_out_in_t;
endpackage : rofd_pkg

//--- rtl/rofd_timer.sv
// Restartable override timer with permanent mode
`timescale 1ns/1ps
module rofd_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_start,
    input  wire logic         i_stop,
    input  wire logic         i_permanent,
    input  wire logic [W-1:0] i_ticks,
    output logic              o_active
);
    logic [W-1:0] cnt_q;
    logic         act_q;
    logic         perm_q;
    wire          expire = act_q && !perm_q && (cnt_q <= W'(1));

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= '0;
            act_q  <= 1'b0;
            perm_q <= 1'b0;
        end else if (i_start) begin
            // A new command restarts the count
            cnt_q  <= i_ticks;
            act_q  <= 1'b1;
            perm_q <= i_permanent;
        end else if (i_stop || expire) begin
            act_q  <= 1'b0;
        end else if (act_q && !perm_q) begin
            cnt_q  <= cnt_q - W'(1);
        end
    end

    assign o_active = act_q;
endmodule : rofd_timer

//--- rtl/rofd_group.sv
// Per-group force and disarm override with output mixing
`timescale 1ns/1ps
module rofd_group #(
    parameter int unsigned N = 8,
    parameter int unsigned W = 32
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [N-1:0] i_normal,
    input  wire logic [N-1:0] i_latched,
    input  wire logic [N-1:0] i_hold_run,
    input  wire logic [N-1:0] i_exempt,
    input  wire logic [N-1:0] i_force_sel,
    input  wire logic [N-1:0] i_force_val,
    input  wire logic         i_grp_force,
    input  wire logic         i_force_perm,
    input  wire logic         i_disarm_en,
    input  wire logic         i_disarm_perm,
    input  wire logic [W-1:0] i_force_ticks,
    input  wire logic [W-1:0] i_disarm_ticks,
    input  wire logic         i_force_cmd,
    input  wire logic         i_force_remove,
    input  wire logic         i_disarm_cmd,
    input  wire logic         i_disarm_wdraw,
    output logic [N-1:0]      o_out,
    output logic [N-1:0]      o_forced,
    output logic [N-1:0]      o_disarmed
);
    logic [N-1:0] dis_pend_q;
    logic         dis_tmr_act;
    logic [N-1:0] dis_act_q;
    logic [N-1:0] out_q;
    wire          dis_start = i_disarm_cmd && i_disarm_en;
    wire  [N-1:0] blocked   = i_latched | i_hold_run;

    // Group-level disarm timer
    rofd_timer #(.W(W)) u_dis_tmr (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_start     (dis_start),
        .i_stop      (i_disarm_wdraw || !i_disarm_en),
        .i_permanent (i_disarm_perm),
        .i_ticks     (i_disarm_ticks),
        .o_active    (dis_tmr_act)
    );

    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_ch
            logic ftmr_act;
            logic fval_q;
            wire  sel = i_grp_force | i_force_sel[k];
            // Force taken only on the direct command, never while disarmed
            wire  fstart = i_force_cmd && sel && !dis_act_q[k];
            rofd_timer #(.W(W)) u_f_tmr (
                .i_core_clk  (i_core_clk),
                .i_rst_n     (i_rst_n),
                .i_start     (fstart),
                .i_stop      (i_force_remove),
                .i_permanent (i_force_perm),
                .i_ticks     (i_force_ticks),
                .o_active    (ftmr_act)
            );
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    fval_q        <= 1'b0;
                    dis_pend_q[k] <= 1'b0;
                    dis_act_q[k]  <= 1'b0;
                    out_q[k]      <= 1'b0;
                end else begin
                    // Group force wins over the single value, so all go to its level
                    if (fstart) begin
                        fval_q <= i_grp_force ? i_force_val[0] : i_force_val[k];
                    end
                    // Disarm waits for latch and hold timer; exempt outputs never disarm
                    // The timer shows active one edge after the command, so the command counts too
                    if ((!dis_tmr_act && !dis_start) || i_exempt[k]) begin
                        dis_pend_q[k] <= 1'b0;
                        dis_act_q[k]  <= 1'b0;
                    end else if (dis_start || dis_pend_q[k]) begin
                        dis_pend_q[k] <= blocked[k];
                        dis_act_q[k]  <= dis_act_q[k] | !blocked[k];
                    end
                    out_q[k] <= dis_act_q[k] ? 1'b0 : (ftmr_act ? fval_q : i_normal[k]);
                end
            end
            assign o_forced[k] = ftmr_act && !dis_act_q[k];
        end
    endgenerate

    assign o_out      = out_q;
    assign o_disarmed = dis_act_q;
endmodule : rofd_group

//--- rtl/rofd_top.sv
// Relay output force/disarm test override, top level with register port
//
// Summary of operation
// - Each output can be forced, permanently or for a timed interval.
// - When the force timer expires, the output follows its normal command.
// - Permanent force holds until software removes it.
// - Whole-group force overrides single-output force in that group.
// - A force request on a disarmed output is ignored.
// - Force applies only after the direct command, and only if not disarmed.
// - Whole groups can be disarmed; disarmed outputs never switch.
// - Zone interlock and supervision outputs are never disarmed.
// - A timed disarm ends when its timer expires.
// - A permanent disarm lasts until withdrawn.
// - Disarm waits while the output is latched and not reset.
// - Disarm waits while the output's off-delay hold timer runs.
// - Disarm needs unlatched idle output, disarm control active and direct command.
// - An operator request triggers a full device reboot.
// - Operational LED lights steady green only once booted and protection runs.
`timescale 1ns/1ps
module rofd_top #(
    parameter int unsigned NUM_GROUPS   = rofd_pkg::NUM_GROUPS,
    parameter int unsigned OUTS_PER_GRP = rofd_pkg::OUTS_PER_GRP,
    parameter int unsigned TMR_W        = rofd_pkg::TMR_W
) (
    input  wire logic                                 i_core_clk,
    input  wire logic                                 i_rst_n,
    input  wire logic [rofd_pkg::ADDR_W-1:0]          i_addr,
    input  wire logic [31:0]                          i_wdata,
    input  wire logic                                 i_wr,
    input  wire logic                                 i_rd,
    output logic      [31:0]                          o_rdata,
    input  wire logic [NUM_GROUPS*OUTS_PER_GRP-1:0]   i_normal_cmd,
    input  wire logic [NUM_GROUPS*OUTS_PER_GRP-1:0]   i_latched,
    input  wire logic [NUM_GROUPS*OUTS_PER_GRP-1:0]   i_hold_run,
    input  wire logic                                 i_boot_done,
    input  wire logic                                 i_prot_running,
    output logic      [NUM_GROUPS*OUTS_PER_GRP-1:0]   o_contact,
    output logic                                      o_reboot_req,
    output logic                                      o_led_green
);
    localparam int unsigned NO = NUM_GROUPS * OUTS_PER_GRP;

    rofd_pkg::rofd_bus_req_t bus;
    rofd_pkg::rofd_out_in_t  oin;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign oin = '{normal_cmd: i_normal_cmd, latched: i_latched, hold_run: i_hold_run};

    logic [NO-1:0]         force_en_q;
    logic [NO-1:0]         force_val_q;
    logic [NUM_GROUPS-1:0] grp_force_q;
    logic [NUM_GROUPS-1:0] force_perm_q;
    logic [TMR_W-1:0]      force_time_q;
    logic [NUM_GROUPS-1:0] disarm_ctrl_q;
    logic [NUM_GROUPS-1:0] disarm_perm_q;
    logic [TMR_W-1:0]      disarm_time_q;
    logic [NO-1:0]         exempt_q;
    logic [31:0]           rdata_q;
    logic                  reboot_q;
    logic [1:0]            boot_s_q;
    logic [1:0]            prot_s_q;
    logic                  led_q;
    logic [NO-1:0]         forced;
    logic [NO-1:0]         disarmed;

    // Address decode
    wire hit_fen   = bus.addr == rofd_pkg::REG_FORCE_EN;
    wire hit_fval  = bus.addr == rofd_pkg::REG_FORCE_VAL;
    wire hit_gfor  = bus.addr == rofd_pkg::REG_GRP_FORCE;
    wire hit_fmode = bus.addr == rofd_pkg::REG_FORCE_MODE;
    wire hit_ftime = bus.addr == rofd_pkg::REG_FORCE_TIME;
    wire hit_dctl  = bus.addr == rofd_pkg::REG_DISARM_CTRL;
    wire hit_dmode = bus.addr == rofd_pkg::REG_DISARM_MODE;
    wire hit_dtime = bus.addr == rofd_pkg::REG_DISARM_TIME;
    wire hit_cmd   = bus.addr == rofd_pkg::REG_COMMAND;
    wire hit_exm   = bus.addr == rofd_pkg::REG_EXEMPT;
    wire hit_stat  = bus.addr == rofd_pkg::REG_STATUS;
    wire hit_ost   = bus.addr == rofd_pkg::REG_OUT_STATE;

    // Command pulses: one cycle, no storage
    wire cmd_wr      = bus.wr && hit_cmd;
    wire c_force     = cmd_wr && bus.wdata[rofd_pkg::CMD_FORCE_APPLY];
    wire c_fremove   = cmd_wr && bus.wdata[rofd_pkg::CMD_FORCE_REMOVE];
    wire c_disarm    = cmd_wr && bus.wdata[rofd_pkg::CMD_DISARM_APPLY];
    wire c_dwdraw    = cmd_wr && bus.wdata[rofd_pkg::CMD_DISARM_WDRAW];
    wire c_reboot    = cmd_wr && bus.wdata[rofd_pkg::CMD_REBOOT];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            force_en_q    <= '0;
            force_val_q   <= '0;
            grp_force_q   <= '0;
            force_perm_q  <= '0;
            force_time_q  <= '0;
            disarm_ctrl_q <= '0;
            disarm_perm_q <= '0;
            disarm_time_q <= '0;
            exempt_q      <= '0;
        end else if (bus.wr) begin
            if (hit_fen)   force_en_q    <= bus.wdata[NO-1:0];
            if (hit_fval)  force_val_q   <= bus.wdata[NO-1:0];
            if (hit_gfor)  grp_force_q   <= bus.wdata[NUM_GROUPS-1:0];
            if (hit_fmode) force_perm_q  <= bus.wdata[NUM_GROUPS-1:0];
            if (hit_ftime) force_time_q  <= bus.wdata[TMR_W-1:0];
            if (hit_dctl)  disarm_ctrl_q <= bus.wdata[NUM_GROUPS-1:0];
            if (hit_dmode) disarm_perm_q <= bus.wdata[NUM_GROUPS-1:0];
            if (hit_dtime) disarm_time_q <= bus.wdata[TMR_W-1:0];
            if (hit_exm)   exempt_q      <= bus.wdata[NO-1:0];
        end
    end

    // Read mux; shifted fields avoid zero-width fillers when the counts change
    logic [NUM_GROUPS-1:0] disarm_act_grp;
    wire [31:0] status_w = (32'(disarm_act_grp) << rofd_pkg::ST_DISARM_LO)
                         | (32'(forced) << rofd_pkg::ST_FORCE_LO)
                         | (32'(led_q) << rofd_pkg::ST_SYSTEM_OK);
    wire [31:0] rd_mux =
        hit_fen   ? 32'(force_en_q)    :
        hit_fval  ? 32'(force_val_q)   :
        hit_gfor  ? 32'(grp_force_q)   :
        hit_fmode ? 32'(force_perm_q)  :
        hit_ftime ? 32'(force_time_q)  :
        hit_dctl  ? 32'(disarm_ctrl_q) :
        hit_dmode ? 32'(disarm_perm_q) :
        hit_dtime ? 32'(disarm_time_q) :
        hit_exm   ? 32'(exempt_q)      :
        hit_stat  ? status_w           :
        hit_ost   ? 32'(disarmed)      :
        rofd_pkg::RD_UNMAP;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= rofd_pkg::RST_WORD;
        end else if (bus.rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= rofd_pkg::RST_WORD;
        end
    end

    // Reboot request is a registered one-cycle pulse
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reboot_q <= 1'b0;
        end else begin
            reboot_q <= c_reboot;
        end
    end

    // Status pins come from outside: three flops, change taken when last two agree
    logic boot_s3_q;
    logic prot_s3_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_s_q  <= '0;
            prot_s_q  <= '0;
            boot_s3_q <= 1'b0;
            prot_s3_q <= 1'b0;
            led_q     <= 1'b0;
        end else begin
            boot_s_q  <= {boot_s_q[0], i_boot_done};
            prot_s_q  <= {prot_s_q[0], i_prot_running};
            boot_s3_q <= boot_s_q[1];
            prot_s3_q <= prot_s_q[1];
            if ((boot_s_q[1] == boot_s3_q) && (prot_s_q[1] == prot_s3_q)) begin
                led_q <= boot_s3_q && prot_s3_q;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
            localparam int unsigned LO = g * OUTS_PER_GRP;
            logic [OUTS_PER_GRP-1:0] dis_g;
            rofd_group #(.N(OUTS_PER_GRP), .W(TMR_W)) u_grp (
                .i_core_clk     (i_core_clk),
                .i_rst_n        (i_rst_n),
                .i_normal       (oin.normal_cmd[LO +: OUTS_PER_GRP]),
                .i_latched      (oin.latched[LO +: OUTS_PER_GRP]),
                .i_hold_run     (oin.hold_run[LO +: OUTS_PER_GRP]),
                .i_exempt       (exempt_q[LO +: OUTS_PER_GRP]),
                .i_force_sel    (force_en_q[LO +: OUTS_PER_GRP]),
                .i_force_val    (force_val_q[LO +: OUTS_PER_GRP]),
                .i_grp_force    (grp_force_q[g]),
                .i_force_perm   (force_perm_q[g]),
                .i_disarm_en    (disarm_ctrl_q[g]),
                .i_disarm_perm  (disarm_perm_q[g]),
                .i_force_ticks  (force_time_q),
                .i_disarm_ticks (disarm_time_q),
                .i_force_cmd    (c_force),
                .i_force_remove (c_fremove),
                .i_disarm_cmd   (c_disarm),
                .i_disarm_wdraw (c_dwdraw),
                .o_out          (o_contact[LO +: OUTS_PER_GRP]),
                .o_forced       (forced[LO +: OUTS_PER_GRP]),
                .o_disarmed     (dis_g)
            );
            assign disarmed[LO +: OUTS_PER_GRP] = dis_g;
            assign disarm_act_grp[g] = |dis_g;
        end
    endgenerate

    assign o_rdata      = rdata_q;
    assign o_reboot_req = reboot_q;
    assign o_led_green  = led_q;
endmodule : rofd_top

//--- verification/rofd_top_chk.sv
// Checker for the relay output force/disarm top level ports
`timescale 1ns/1ps
module rofd_top_chk #(
    parameter int unsigned NUM_GROUPS   = 2,
    parameter int unsigned OUTS_PER_GRP = 8,
    parameter int unsigned TMR_W        = 32
) (
    input wire logic                               i_core_clk,
    input wire logic                               i_rst_n,
    input wire logic [7:0]                         i_addr,
    input wire logic [31:0]                        i_wdata,
    input wire logic                               i_wr,
    input wire logic                               i_rd,
    input wire logic [31:0]                        o_rdata,
    input wire logic [NUM_GROUPS*OUTS_PER_GRP-1:0] i_normal_cmd,
    input wire logic                               i_boot_done,
    input wire logic                               i_prot_running,
    input wire logic [NUM_GROUPS*OUTS_PER_GRP-1:0] o_contact,
    input wire logic                               o_reboot_req,
    input wire logic                               o_led_green
);
    wire  cmd_wr    = i_wr && (i_addr == rofd_pkg::REG_COMMAND);
    wire  reboot_wr = cmd_wr && i_wdata[rofd_pkg::CMD_REBOOT];
    wire  healthy   = i_boot_done && i_prot_running;
    logic live_q;
    logic ovr_q;

    // Pass-through is only provable until the first override command
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            live_q <= 1'b0;
            ovr_q  <= 1'b0;
        end else begin
            live_q <= 1'b1;
            ovr_q  <= ovr_q | (cmd_wr & (i_wdata[0] | i_wdata[2]));
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    chk_unmapped_read: assert property (i_rd && i_addr == 8'h30 |=> o_rdata == rofd_pkg::RD_UNMAP)
        else $error("unmapped read not zero");
    chk_upper_bits: assert property (i_rd && i_addr == rofd_pkg::REG_OUT_STATE |=> o_rdata[31:16] == 16'h0)
        else $error("upper bits of output state not zero");
    chk_status_led: assert property (i_rd && i_addr == rofd_pkg::REG_STATUS |=> o_rdata[0] == $past(o_led_green))
        else $error("status bit 0 differs from led");
    chk_reboot_cause: assert property (reboot_wr |=> o_reboot_req)
        else $error("reboot write gave no pulse");
    chk_reboot_origin: assert property (o_reboot_req |-> $past(reboot_wr))
        else $error("reboot pulse without request");
    chk_reboot_pulse: assert property (o_reboot_req |=> !o_reboot_req)
        else $error("reboot pulse longer than one cycle");
    chk_led_on: assert property (healthy [*6] |-> o_led_green)
        else $error("led not green while running");
    chk_led_off: assert property ((!healthy) [*6] |-> !o_led_green)
        else $error("led green while not running");
    chk_contact_pass: assert property (live_q && !ovr_q |-> o_contact == $past(i_normal_cmd))
        else $error("contact differs from normal command");
endmodule : rofd_top_chk

bind rofd_top rofd_top_chk #(
    .NUM_GROUPS  (NUM_GROUPS),
    .OUTS_PER_GRP(OUTS_PER_GRP),
    .TMR_W       (TMR_W)
) u_chk (
    .i_core_clk    (i_core_clk),
    .i_rst_n       (i_rst_n),
    .i_addr        (i_addr),
    .i_wdata       (i_wdata),
    .i_wr          (i_wr),
    .i_rd          (i_rd),
    .o_rdata       (o_rdata),
    .i_normal_cmd  (i_normal_cmd),
    .i_boot_done   (i_boot_done),
    .i_prot_running(i_prot_running),
    .o_contact     (o_contact),
    .o_reboot_req  (o_reboot_req),
    .o_led_green   (o_led_green)
);

//--- verification/rofd_field.sv
// Far-side model: protection commands, contact latch and hold state, boot status
`timescale 1ns/1ps
module rofd_field (
    input  wire logic               i_core_clk,
    input  wire logic               i_rst_n,
    input  wire logic [15:0]        i_cmd_set,
    input  wire logic [15:0]        i_latch_set,
    input  wire logic [15:0]        i_hold_set,
    input  wire logic               i_boot_set,
    input  wire logic               i_prot_set,
    output rofd_pkg::rofd_out_in_t  o_drv,
    output logic                    o_boot_done,
    output logic                    o_prot_running
);
    // Registered so every level changes just after an edge, like real logic
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drv          <= '0;
            o_boot_done    <= 1'b0;
            o_prot_running <= 1'b0;
        end else begin
            o_drv          <= {i_cmd_set, i_latch_set, i_hold_set};
            o_boot_done    <= i_boot_set;
            o_prot_running <= i_prot_set;
        end
    end
endmodule : rofd_field

//--- verification/tb.sv
// Self-checking bench for the relay output force/disarm block
`timescale 1ns/1ps
module tb;
    logic                   clk      = 1'b0;
    logic                   rst_n    = 1'b0;
    logic [7:0]             addr     = 8'h00;
    logic [31:0]            wdata    = 32'h0;
    logic                   wr       = 1'b0;
    logic                   rd       = 1'b0;
    logic [15:0]            nrm_set  = 16'h0;
    logic [15:0]            lat_set  = 16'h0;
    logic [15:0]            hold_set = 16'h0;
    logic                   boot_set = 1'b0;
    logic                   prot_set = 1'b0;
    logic                   seen;
    logic [31:0]            rdata;
    logic [15:0]            contact;
    logic                   reboot;
    logic                   led;
    logic                   boot;
    logic                   prot;
    rofd_pkg::rofd_out_in_t drv;
    int                     fail_count   = 0;
    int                     total_checks = 0;

    always #25 clk = ~clk;

    rofd_field u_rofd_field (.i_core_clk(clk), .i_rst_n(rst_n), .i_cmd_set(nrm_set),
        .i_latch_set(lat_set), .i_hold_set(hold_set), .i_boot_set(boot_set),
        .i_prot_set(prot_set), .o_drv(drv), .o_boot_done(boot), .o_prot_running(prot));

    rofd_top u_rofd_top (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_normal_cmd(drv.normal_cmd),
        .i_latched(drv.latched), .i_hold_run(drv.hold_run), .i_boot_done(boot),
        .i_prot_running(prot), .o_contact(contact), .o_reboot_req(reboot), .o_led_green(led));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask : rd_reg

    // Contacts are compared zero-extended
    task automatic chk_out(input logic [15:0] exp);
        chk({16'h0, contact}, {16'h0, exp}, "contacts");
    endtask : chk_out

    initial begin
        #(50 * 20000);
        fail_count++;
        $display("CHECK FAILED t=%0t run timed out", $time);
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        for (int a = 0; a <= 'h30; a += 4)
            rd_reg(a[7:0], rofd_pkg::RST_WORD, "reset value");
        $display("test reset values done");

        boot_set <= 1'b1;
        cyc(10);
        chk({31'h0, led}, 32'h0, "led without protection");
        prot_set <= 1'b1;
        cyc(10);
        chk({31'h0, led}, 32'h1, "led running");
        rd_reg(rofd_pkg::REG_STATUS, 32'h1, "status led");
        wr_reg(rofd_pkg::REG_COMMAND, 32'h10);
        // The pulse stands from the write edge to the next one, so look before waiting
        seen = 1'b0;
        for (int i = 0; i < 4; i++) begin
            #1;
            if (reboot === 1'b1)
                seen = 1'b1;
            @(posedge clk);
        end
        chk({31'h0, seen}, 32'h1, "reboot pulse");
        $display("test led and reboot done");

        nrm_set <= 16'h00F0;
        wr_reg(rofd_pkg::REG_FORCE_EN, 32'h1);
        wr_reg(rofd_pkg::REG_FORCE_VAL, 32'h1);
        wr_reg(rofd_pkg::REG_FORCE_TIME, 32'h5);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h1);
        cyc(2);
        chk_out(16'h00F1);
        rd_reg(rofd_pkg::REG_STATUS, 32'h101, "status forced");
        cyc(12);
        chk_out(16'h00F0);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h1);
        cyc(2);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h1);
        cyc(4);
        chk_out(16'h00F1);
        cyc(10);
        chk_out(16'h00F0);
        $display("test timed force done");

        // Single select says 0 on output 1, the group force must win
        wr_reg(rofd_pkg::REG_FORCE_EN, 32'h2);
        wr_reg(rofd_pkg::REG_GRP_FORCE, 32'h1);
        wr_reg(rofd_pkg::REG_FORCE_MODE, 32'h1);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h1);
        cyc(2);
        chk_out(16'h00FF);
        cyc(60);
        chk_out(16'h00FF);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h2);
        cyc(3);
        chk_out(16'h00F0);
        wr_reg(rofd_pkg::REG_GRP_FORCE, 32'h0);
        $display("test group force done");

        nrm_set  <= 16'hFFFF;
        lat_set  <= 16'h0001;
        hold_set <= 16'h0002;
        wr_reg(rofd_pkg::REG_EXEMPT, 32'h80);
        wr_reg(rofd_pkg::REG_DISARM_MODE, 32'h1);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h4);
        cyc(3);
        chk_out(16'hFFFF);
        wr_reg(rofd_pkg::REG_DISARM_CTRL, 32'h1);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h4);
        cyc(3);
        chk_out(16'hFF83);
        rd_reg(rofd_pkg::REG_OUT_STATE, 32'h7C, "disarmed set");
        lat_set  <= 16'h0;
        hold_set <= 16'h0;
        cyc(4);
        chk_out(16'hFF80);
        wr_reg(rofd_pkg::REG_FORCE_EN, 32'h4);
        // Force value differs from normal, so a wrongly taken force shows after withdraw
        wr_reg(rofd_pkg::REG_FORCE_VAL, 32'h0);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h1);
        cyc(40);
        chk_out(16'hFF80);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h8);
        cyc(3);
        chk_out(16'hFFFF);
        wr_reg(rofd_pkg::REG_DISARM_MODE, 32'h0);
        wr_reg(rofd_pkg::REG_DISARM_TIME, 32'h6);
        wr_reg(rofd_pkg::REG_COMMAND, 32'h4);
        cyc(3);
        chk_out(16'hFF80);
        cyc(12);
        chk_out(16'hFFFF);
        $display("test disarm done");
        results();
    end
endmodule : tb
